/* File: src/crs_pkg.sv */
// package: constants and types for the cpu register set
package crs_pkg;
    // ======================================================
    // widths and indices
    localparam int unsigned CRS_XLEN      = 32;
    localparam int unsigned CRS_ACC_W     = 64;
    localparam int unsigned CRS_NGPR      = 16;
    localparam int unsigned CRS_GPR_AW    = 4;
    localparam logic [3:0]  CRS_SP_INDEX  = 4'h0;
    localparam int unsigned CRS_PSW_U_BIT = 17;
    localparam int unsigned CRS_FP_NEXC   = 5;
    // accumulator slices
    localparam int unsigned CRS_ACC_HI_LSB  = 32;
    localparam int unsigned CRS_ACC_MID_LSB = 16;
    // ======================================================
    // reset values
    localparam logic [31:0] CRS_RST_WORD = 32'h0000_0000;
    localparam logic [63:0] CRS_RST_ACC  = 64'h0000_0000_0000_0000;
    localparam logic [4:0]  CRS_RST_FP   = 5'h00;
    // ======================================================
    // control register selector
    typedef enum logic [2:0] {
        CRS_CR_ISP,
        CRS_CR_USP,
        CRS_CR_VTB,
        CRS_CR_PSW,
        CRS_CR_SPC,
        CRS_CR_SPSW,
        CRS_CR_FIV
    } crs_creg_t;
    // accumulator write operations
    typedef enum logic [1:0] {
        CRS_ACC_NONE,
        CRS_ACC_FULL,
        CRS_ACC_HI,
        CRS_ACC_LO
    } crs_accop_t;
endpackage

/* File: src/crs_gpr_mem.sv */
// file: general register storage array, r1..r15, registered read ports
`timescale 1ns/1ps
module crs_gpr_mem
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // write port
    input  wire logic                  we_i,
    input  wire logic [CRS_GPR_AW-1:0] waddr_i,
    input  wire logic [CRS_XLEN-1:0]   wdata_i,
    // read ports
    input  wire logic [CRS_GPR_AW-1:0] raddr_a_i,
    input  wire logic [CRS_GPR_AW-1:0] raddr_b_i,
    output logic      [CRS_XLEN-1:0]   rdata_a_o,
    output logic      [CRS_XLEN-1:0]   rdata_b_o
);
    logic [CRS_XLEN-1:0] mem_ff [CRS_NGPR];

    // ======================================================
    // storage, one generate loop over entries
    genvar g;
    generate
        for (g = 0; g < CRS_NGPR; g++) begin : g_ent
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    mem_ff[g] <= CRS_RST_WORD;
                end else if (we_i && (waddr_i == CRS_GPR_AW'(g))) begin
                    mem_ff[g] <= wdata_i;
                end
            end
        end
    endgenerate

    // registered read data
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_a_o <= CRS_RST_WORD;
            rdata_b_o <= CRS_RST_WORD;
        end else begin
            rdata_a_o <= mem_ff[raddr_a_i];
            rdata_b_o <= mem_ff[raddr_b_i];
        end
    end
endmodule

/* File: src/crs_top.sv */
// file: programmer-visible register set of the cpu core
// Summary of operation
// - sixteen general registers, r1-r15 general purpose
// - r0 accesses the active stack pointer
// - psw u bit picks user or interrupt
// - vector table base held for vector lookup
// - program counter holds executing instruction address
// - fast interrupt saves pc into backup
// - fast interrupt saves psw, same layout
// - fast interrupt branches to fast vector
// - enabled fp exception sets cause flag
// - masked fp exception sets sticky until cleared
// - sixty-four bit dsp accumulator provided
// - multiply instructions overwrite whole accumulator
// - move-to writes high or low half
// - move-from reads high or middle slice
`timescale 1ns/1ps
module crs_top
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // general register write
    input  wire logic                  gpr_we_i,
    input  wire logic [CRS_GPR_AW-1:0] gpr_waddr_i,
    input  wire logic [CRS_XLEN-1:0]   gpr_wdata_i,
    // general register read
    input  wire logic [CRS_GPR_AW-1:0] gpr_raddr_a_i,
    input  wire logic [CRS_GPR_AW-1:0] gpr_raddr_b_i,
    output logic      [CRS_XLEN-1:0]   gpr_rdata_a_o,
    output logic      [CRS_XLEN-1:0]   gpr_rdata_b_o,
    // control register write
    input  wire logic                  creg_we_i,
    input  wire crs_creg_t             creg_sel_i,
    input  wire logic [CRS_XLEN-1:0]   creg_wdata_i,
    // program counter
    input  wire logic                  pc_we_i,
    input  wire logic [CRS_XLEN-1:0]   pc_next_i,
    // fast interrupt entry
    input  wire logic                  fast_irq_take_i,
    // floating point status
    input  wire logic                  float_status_word_we_i,
    input  wire logic [CRS_FP_NEXC-1:0] fp_enable_wdata_i,
    input  wire logic [CRS_FP_NEXC-1:0] fp_cause_wdata_i,
    input  wire logic [CRS_FP_NEXC-1:0] fp_sticky_wdata_i,
    input  wire logic [CRS_FP_NEXC-1:0] fp_exc_i,
    // accumulator
    input  wire crs_accop_t            acc_op_i,
    input  wire logic [CRS_ACC_W-1:0]  acc_full_i,
    input  wire logic [CRS_XLEN-1:0]   acc_half_i,
    // control register outputs
    output logic      [CRS_XLEN-1:0]   interrupt_stack_pointer_o,
    output logic      [CRS_XLEN-1:0]   user_stack_pointer_o,
    output logic      [CRS_XLEN-1:0]   vector_table_base_o,
    output logic      [CRS_XLEN-1:0]   program_counter_o,
    output logic      [CRS_XLEN-1:0]   processor_status_word_o,
    output logic      [CRS_XLEN-1:0]   saved_program_counter_o,
    output logic      [CRS_XLEN-1:0]   saved_status_word_o,
    output logic      [CRS_XLEN-1:0]   fast_irq_vector_o,
    // floating point flags
    output logic      [CRS_FP_NEXC-1:0] fp_trap_enable_o,
    output logic      [CRS_FP_NEXC-1:0] fp_cause_flag_o,
    output logic      [CRS_FP_NEXC-1:0] fp_sticky_flag_o,
    // accumulator views
    output logic      [CRS_ACC_W-1:0]  dsp_sum_register_o,
    output logic      [CRS_XLEN-1:0]   acc_high_o,
    output logic      [CRS_XLEN-1:0]   acc_middle_o
);
    // ======================================================
    // state
    logic [CRS_XLEN-1:0]    isp_ff, usp_ff, vtb_ff, pc_ff, psw_ff;
    logic [CRS_XLEN-1:0]    spc_ff, spsw_ff, fiv_ff;
    logic [CRS_FP_NEXC-1:0] fen_ff, fcause_ff, fsticky_ff;
    logic [CRS_ACC_W-1:0]   acc_ff;
    logic                   user_sel;
    logic [CRS_XLEN-1:0]    mem_a, mem_b;
    logic                   sp_rd_a_ff, sp_rd_b_ff;
    logic                   mem_we, sp_we;

    assign user_sel = psw_ff[CRS_PSW_U_BIT];

    // ======================================================
    // general registers; r0 goes to the banked stack pointer
    assign mem_we = gpr_we_i && (gpr_waddr_i != CRS_SP_INDEX);
    assign sp_we  = gpr_we_i && (gpr_waddr_i == CRS_SP_INDEX);

    crs_gpr_mem u_mem (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .we_i      (mem_we),
        .waddr_i   (gpr_waddr_i),
        .wdata_i   (gpr_wdata_i),
        .raddr_a_i (gpr_raddr_a_i),
        .raddr_b_i (gpr_raddr_b_i),
        .rdata_a_o (mem_a),
        .rdata_b_o (mem_b)
    );

    // remember whether each read port addressed r0
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sp_rd_a_ff <= 1'b0;
            sp_rd_b_ff <= 1'b0;
        end else begin
            sp_rd_a_ff <= (gpr_raddr_a_i == CRS_SP_INDEX);
            sp_rd_b_ff <= (gpr_raddr_b_i == CRS_SP_INDEX);
        end
    end

    // r0 reads return the active stack pointer, one cycle after address
    logic [CRS_XLEN-1:0] sp_q_ff;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sp_q_ff <= CRS_RST_WORD;
        end else begin
            sp_q_ff <= user_sel ? usp_ff : isp_ff;
        end
    end
    assign gpr_rdata_a_o = sp_rd_a_ff ? sp_q_ff : mem_a;
    assign gpr_rdata_b_o = sp_rd_b_ff ? sp_q_ff : mem_b;

    // ======================================================
    // stack pointers; r0 write updates the selected bank
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            isp_ff <= CRS_RST_WORD;
            usp_ff <= CRS_RST_WORD;
        end else begin
            if (sp_we && !user_sel) begin
                isp_ff <= gpr_wdata_i;
            end else if (creg_we_i && creg_sel_i == CRS_CR_ISP) begin
                isp_ff <= creg_wdata_i;
            end
            if (sp_we && user_sel) begin
                usp_ff <= gpr_wdata_i;
            end else if (creg_we_i && creg_sel_i == CRS_CR_USP) begin
                usp_ff <= creg_wdata_i;
            end
        end
    end

    // vector table base and fast vector
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            vtb_ff <= CRS_RST_WORD;
            fiv_ff <= CRS_RST_WORD;
        end else begin
            if (creg_we_i && creg_sel_i == CRS_CR_VTB) begin
                vtb_ff <= creg_wdata_i;
            end
            if (creg_we_i && creg_sel_i == CRS_CR_FIV) begin
                fiv_ff <= creg_wdata_i;
            end
        end
    end

    // program counter; fast interrupt entry beats a normal update
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_ff <= CRS_RST_WORD;
        end else if (fast_irq_take_i) begin
            pc_ff <= fiv_ff;
        end else if (pc_we_i) begin
            pc_ff <= pc_next_i;
        end
    end

    // status word and backups
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            psw_ff  <= CRS_RST_WORD;
            spc_ff  <= CRS_RST_WORD;
            spsw_ff <= CRS_RST_WORD;
        end else begin
            if (creg_we_i && creg_sel_i == CRS_CR_PSW) begin
                psw_ff <= creg_wdata_i;
            end
            if (fast_irq_take_i) begin
                spc_ff  <= pc_ff;
                spsw_ff <= psw_ff;
            end else begin
                if (creg_we_i && creg_sel_i == CRS_CR_SPC) begin
                    spc_ff <= creg_wdata_i;
                end
                if (creg_we_i && creg_sel_i == CRS_CR_SPSW) begin
                    spsw_ff <= creg_wdata_i;
                end
            end
        end
    end

    // ======================================================
    // floating point status; hardware set wins over software clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fen_ff     <= CRS_RST_FP;
            fcause_ff  <= CRS_RST_FP;
            fsticky_ff <= CRS_RST_FP;
        end else begin
            if (float_status_word_we_i) begin
                fen_ff <= fp_enable_wdata_i;
            end
            fcause_ff  <= (float_status_word_we_i ? fp_cause_wdata_i : fcause_ff)
                          | (fp_exc_i & fen_ff);
            fsticky_ff <= (float_status_word_we_i ? fp_sticky_wdata_i : fsticky_ff)
                          | (fp_exc_i & ~fen_ff);
        end
    end

    // ======================================================
    // accumulator
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_ff <= CRS_RST_ACC;
        end else begin
            case (acc_op_i)
                CRS_ACC_FULL: acc_ff <= acc_full_i;
                CRS_ACC_HI: acc_ff[CRS_ACC_W-1:CRS_ACC_HI_LSB] <= acc_half_i;
                CRS_ACC_LO: acc_ff[CRS_ACC_HI_LSB-1:0] <= acc_half_i;
                default: acc_ff <= acc_ff;
            endcase
        end
    end

    assign acc_high_o   = acc_ff[CRS_ACC_W-1:CRS_ACC_HI_LSB];
    assign acc_middle_o = acc_ff[CRS_ACC_MID_LSB+CRS_XLEN-1:CRS_ACC_MID_LSB];

    // ======================================================
    // outputs
    assign interrupt_stack_pointer_o = isp_ff;
    assign user_stack_pointer_o      = usp_ff;
    assign vector_table_base_o       = vtb_ff;
    assign program_counter_o         = pc_ff;
    assign processor_status_word_o   = psw_ff;
    assign saved_program_counter_o   = spc_ff;
    assign saved_status_word_o       = spsw_ff;
    assign fast_irq_vector_o         = fiv_ff;
    assign fp_trap_enable_o          = fen_ff;
    assign fp_cause_flag_o           = fcause_ff;
    assign fp_sticky_flag_o          = fsticky_ff;
    assign dsp_sum_register_o        = acc_ff;

    // ======================================================
    // checks
    sequence s_fast_entry;
        fast_irq_take_i;
    endsequence

    chk_fast_pc_save: assert property (@(posedge clk_i) disable iff (reset_i)
        s_fast_entry |=> spc_ff == $past(pc_ff)) else $error("pc not saved");
    chk_fast_psw_save: assert property (@(posedge clk_i) disable iff (reset_i)
        s_fast_entry |=> spsw_ff == $past(psw_ff)) else $error("psw not saved");
    chk_fast_branch: assert property (@(posedge clk_i) disable iff (reset_i)
        s_fast_entry |=> pc_ff == $past(fiv_ff)) else $error("no fast branch");
    chk_sticky_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (fsticky_ff[0] && !float_status_word_we_i) |=> fsticky_ff[0]) else $error("sticky lost");
    chk_sticky_set: assert property (@(posedge clk_i) disable iff (reset_i)
        (|(fp_exc_i & ~fen_ff))
        |=> ((fsticky_ff & $past(fp_exc_i & ~fen_ff)) == $past(fp_exc_i & ~fen_ff)))
        else $error("sticky not set");
    chk_cause_set: assert property (@(posedge clk_i) disable iff (reset_i)
        (fp_exc_i[2] && fen_ff[2]) |=> fcause_ff[2]) else $error("cause not set");
    chk_acc_hi_write: assert property (@(posedge clk_i) disable iff (reset_i)
        acc_op_i == CRS_ACC_HI |=> acc_high_o == $past(acc_half_i)
        && acc_ff[CRS_ACC_HI_LSB-1:0] == $past(acc_ff[CRS_ACC_HI_LSB-1:0])) else $error("acc high write");
    chk_sp_bank: assert property (@(posedge clk_i) disable iff (reset_i)
        (sp_we && user_sel && !(creg_we_i && creg_sel_i == CRS_CR_ISP))
        |=> isp_ff == $past(isp_ff) && usp_ff == $past(gpr_wdata_i)) else $error("wrong sp bank");
endmodule

/* File: sim/crs_pipe_model.sv */
// pipeline model that drives the register set's request ports
`timescale 1ns/1ps
module crs_pipe_model
    import crs_pkg::*;
(
    // clock
    input  wire logic  clk_i,
    // general register requests
    output logic       gpr_we_o,
    output logic [3:0] gpr_waddr_o,
    output logic [31:0] gpr_wdata_o,
    output logic [3:0] raddr_a_o,
    output logic [3:0] raddr_b_o,
    // control register, pc and fast interrupt requests
    output logic       creg_we_o,
    output crs_creg_t  creg_sel_o,
    output logic [31:0] creg_wdata_o,
    output logic       pc_we_o,
    output logic [31:0] pc_next_o,
    output logic       irq_o,
    // floating point and accumulator requests
    output logic       float_status_word_we_o,
    output logic [4:0] fp_en_o,
    output logic [4:0] fp_cause_o,
    output logic [4:0] fp_sticky_o,
    output logic [4:0] fp_exc_o,
    output crs_accop_t acc_op_o,
    output logic [63:0] acc_full_o,
    output logic [31:0] acc_half_o
);
    // ======================================================
    // idle state: strobes low, gpr, creg, pc and full accumulator data lines toggled so no stale value lingers
    task automatic idle();
        {gpr_we_o, creg_we_o, pc_we_o, irq_o, float_status_word_we_o} = '0;
        fp_exc_o = 5'h00;
        acc_op_o = CRS_ACC_NONE;
        gpr_wdata_o = ~gpr_wdata_o;
        creg_wdata_o = ~creg_wdata_o;
        pc_next_o = ~pc_next_o;
        acc_full_o = ~acc_full_o;
    endtask
    // every input has a value from time zero
    initial begin
        {gpr_waddr_o, gpr_wdata_o, raddr_a_o, raddr_b_o, creg_wdata_o, pc_next_o} = '0;
        {fp_en_o, fp_cause_o, fp_sticky_o, acc_full_o, acc_half_o} = '0;
        creg_sel_o = CRS_CR_ISP;
        idle();
    end
    // ======================================================
    // requests: set at a falling edge, taken at the next rising edge,
    // then one idle cycle so no strobe is assigned twice in one time step
    task automatic cyc();
        @(negedge clk_i);
        idle();
        @(negedge clk_i);
    endtask
    task automatic gpr_wr(input logic [3:0] a, input logic [31:0] d);
        gpr_we_o = 1'b1;
        gpr_waddr_o = a;
        gpr_wdata_o = (a == CRS_SP_INDEX) ? {d[31:2], 2'b00} : d;
        cyc();
    endtask
    task automatic creg_wr(input crs_creg_t s, input logic [31:0] d);
        creg_we_o = 1'b1;
        creg_sel_o = s;
        creg_wdata_o = d;
        cyc();
    endtask
    task automatic pc_wr(input logic [31:0] d);
        pc_we_o = 1'b1;
        pc_next_o = d;
        cyc();
    endtask
    task automatic irq(input logic with_pc, input logic [31:0] d);
        pc_we_o = with_pc;
        pc_next_o = d;
        irq_o = 1'b1;
        cyc();
    endtask
    task automatic float_status_word_wr(input logic [4:0] en, input logic [4:0] c, input logic [4:0] s);
        float_status_word_we_o = 1'b1;
        {fp_en_o, fp_cause_o, fp_sticky_o} = {en, c, s};
        cyc();
    endtask
    task automatic fp_evt(input logic [4:0] e);
        fp_exc_o = e;
        cyc();
    endtask
    task automatic acc_wr(input crs_accop_t op, input logic [63:0] f, input logic [31:0] h);
        acc_op_o = op;
        acc_full_o = f;
        acc_half_o = h;
        cyc();
    endtask
    task automatic rd(input logic [3:0] a, input logic [3:0] b);
        raddr_a_o = a;
        raddr_b_o = b;
        @(negedge clk_i);
    endtask
endmodule

/* File: sim/tb_cpu_register_set.sv */
// self-checking testbench for the cpu register set
`timescale 1ns/1ps
module tb_cpu_register_set
    import crs_pkg::*;
;
    // ======================================================
    // nets and counters
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        gpr_we_o, creg_we_o, pc_we_o, irq_o, float_status_word_we_o;
    logic [3:0]  gpr_waddr_o, raddr_a_o, raddr_b_o;
    crs_creg_t   creg_sel_o;
    crs_accop_t  acc_op_o;
    logic [4:0]  fp_en_o, fp_cause_o, fp_sticky_o, fp_exc_o, fp_trap_enable_o, fp_cause_flag_o, fp_sticky_flag_o;
    logic [63:0] acc_full_o, dsp_sum_register_o;
    logic [31:0] gpr_wdata_o, creg_wdata_o, pc_next_o, acc_half_o, gpr_rdata_a_o, gpr_rdata_b_o;
    logic [31:0] interrupt_stack_pointer_o, user_stack_pointer_o, vector_table_base_o, program_counter_o;
    logic [31:0] processor_status_word_o, saved_program_counter_o, saved_status_word_o, fast_irq_vector_o;
    logic [31:0] acc_high_o, acc_middle_o;
    int          failures = 0;
    int          check_count = 0;
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    // ======================================================
    // partner and design
    crs_pipe_model u_pipe (.clk_i, .gpr_we_o, .gpr_waddr_o, .gpr_wdata_o, .raddr_a_o, .raddr_b_o, .creg_we_o,
        .creg_sel_o, .creg_wdata_o, .pc_we_o, .pc_next_o, .irq_o, .float_status_word_we_o, .fp_en_o, .fp_cause_o,
        .fp_sticky_o, .fp_exc_o, .acc_op_o, .acc_full_o, .acc_half_o);
    crs_top u_dut (.clk_i, .reset_i, .gpr_we_i(gpr_we_o), .gpr_waddr_i(gpr_waddr_o), .gpr_wdata_i(gpr_wdata_o),
        .gpr_raddr_a_i(raddr_a_o), .gpr_raddr_b_i(raddr_b_o), .gpr_rdata_a_o, .gpr_rdata_b_o,
        .creg_we_i(creg_we_o), .creg_sel_i(creg_sel_o), .creg_wdata_i(creg_wdata_o), .pc_we_i(pc_we_o),
        .pc_next_i(pc_next_o), .fast_irq_take_i(irq_o), .float_status_word_we_i(float_status_word_we_o), .fp_enable_wdata_i(fp_en_o),
        .fp_cause_wdata_i(fp_cause_o), .fp_sticky_wdata_i(fp_sticky_o), .fp_exc_i(fp_exc_o),
        .acc_op_i(acc_op_o), .acc_full_i(acc_full_o), .acc_half_i(acc_half_o), .interrupt_stack_pointer_o,
        .user_stack_pointer_o, .vector_table_base_o, .program_counter_o, .processor_status_word_o,
        .saved_program_counter_o, .saved_status_word_o, .fast_irq_vector_o, .fp_trap_enable_o,
        .fp_cause_flag_o, .fp_sticky_flag_o, .dsp_sum_register_o, .acc_high_o, .acc_middle_o);
    // ======================================================
    // compare and closing
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ======================================================
    // scenarios
    task automatic t_gpr();
        for (int i = 1; i < 16; i++) begin
            u_pipe.gpr_wr(4'(i), 32'hA5A5_0000 | 32'(i));
        end
        for (int i = 1; i < 16; i++) begin
            u_pipe.rd(4'(i), 4'(16 - i));
            check(gpr_rdata_a_o, 32'hA5A5_0000 | 32'(i));
            check(gpr_rdata_b_o, 32'hA5A5_0000 | 32'(16 - i));
        end
        $display("test gpr done");
    endtask
    task automatic t_stack();
        u_pipe.creg_wr(CRS_CR_PSW, 32'h0000_0000);
        u_pipe.gpr_wr(4'h0, 32'h0000_1000);
        check(interrupt_stack_pointer_o, 32'h0000_1000);
        u_pipe.creg_wr(CRS_CR_PSW, 32'h1 << CRS_PSW_U_BIT);
        u_pipe.gpr_wr(4'h0, 32'h0000_2000);
        check(user_stack_pointer_o, 32'h0000_2000);
        check(interrupt_stack_pointer_o, 32'h0000_1000);
        u_pipe.rd(4'h0, 4'h1);
        check(gpr_rdata_a_o, 32'h0000_2000);
        u_pipe.creg_wr(CRS_CR_PSW, 32'h0000_0000);
        u_pipe.rd(4'h0, 4'h0);
        check(gpr_rdata_b_o, 32'h0000_1000);
        $display("test stack done");
    endtask
    task automatic t_irq();
        u_pipe.creg_wr(CRS_CR_VTB, 32'h0001_0000);
        check(vector_table_base_o, 32'h0001_0000);
        u_pipe.irq(1'b0, 32'h0);
        u_pipe.pc_wr(32'h0000_0400);
        check(program_counter_o, 32'h0000_0400);
        u_pipe.creg_wr(CRS_CR_PSW, 32'h0002_0005);
        u_pipe.creg_wr(CRS_CR_FIV, 32'hFFFF_0100);
        check(fast_irq_vector_o, 32'hFFFF_0100);
        u_pipe.irq(1'b1, 32'h0000_0404);
        check(saved_program_counter_o, 32'h0000_0400);
        check(saved_status_word_o, 32'h0002_0005);
        check(program_counter_o, 32'hFFFF_0100);
        check(processor_status_word_o, 32'h0002_0005);
        $display("test fast interrupt done");
    endtask
    task automatic t_fp();
        u_pipe.float_status_word_wr(5'h0A, 5'h00, 5'h00);
        check(fp_trap_enable_o, 5'h0A);
        u_pipe.fp_evt(5'h1F);
        check(fp_cause_flag_o, 5'h0A);
        check(fp_sticky_flag_o, 5'h15);
        u_pipe.fp_evt(5'h00);
        check(fp_sticky_flag_o, 5'h15);
        u_pipe.float_status_word_wr(5'h1F, 5'h00, 5'h00);
        check(fp_sticky_flag_o, 5'h00);
        u_pipe.fp_evt(5'h04);
        check(fp_cause_flag_o, 5'h04);
        check(fp_sticky_flag_o, 5'h00);
        $display("test fp done");
    endtask
    task automatic t_acc();
        u_pipe.acc_wr(CRS_ACC_FULL, 64'h1122_3344_5566_7788, 32'hFFFF_FFFF);
        check(dsp_sum_register_o, 64'h1122_3344_5566_7788);
        check(acc_high_o, 32'h1122_3344);
        check(acc_middle_o, 32'h3344_5566);
        u_pipe.acc_wr(CRS_ACC_HI, 64'hFFFF_FFFF_FFFF_FFFF, 32'hDEAD_BEEF);
        check(dsp_sum_register_o, 64'hDEAD_BEEF_5566_7788);
        u_pipe.acc_wr(CRS_ACC_LO, 64'hFFFF_FFFF_FFFF_FFFF, 32'h0BAD_F00D);
        check(dsp_sum_register_o, 64'hDEAD_BEEF_0BAD_F00D);
        check(acc_middle_o, 32'hBEEF_0BAD);
        u_pipe.acc_wr(CRS_ACC_FULL, 64'hFFFF_0000_0000_0001, 32'h0);
        check(dsp_sum_register_o, 64'hFFFF_0000_0000_0001);
        $display("test accumulator done");
    endtask
    // ======================================================
    // main sequence
    initial begin
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        check(program_counter_o, 32'h0000_0000);
        t_gpr();
        t_stack();
        t_irq();
        t_fp();
        t_acc();
        summarize();
    end
    // watchdog, far beyond the hundred or so cycles the tests take
    initial begin
        repeat (2000) @(posedge clk_i);
        failures++;
        summarize();
    end
endmodule
